/* hw/psr_pkg.sv */
package psr_pkg;

   // Register numbers within the processor status space.
   localparam logic [7:0]  REG_VECTOR_BASE   = 8'h01;
   localparam logic [7:0]  REG_TILE_CONTROL  = 8'h02;
   localparam logic [7:0]  REG_BOOT_STATUS   = 8'h03;
   localparam logic [7:0]  REG_SECURITY_CFG  = 8'h05;
   localparam logic [7:0]  REG_RING_CONTROL  = 8'h06;
   localparam logic [7:0]  REG_RING_COUNT0   = 8'h07;
   localparam logic [7:0]  REG_RAM_SIZE      = 8'h0C;
   localparam int          RING_COUNT_NUM    = 4;

   // Resource identifier layout.
   localparam logic [7:0]  RES_TYPE_STATUS   = 8'h0B;
   localparam int          RES_REG_SHIFT     = 8;

   // Writable bits of each register.
   localparam logic [31:0] VECTOR_WR_MASK    = 32'hFFFC_0000;
   localparam logic [31:0] TILE_WR_MASK      = 32'h03FF_FF36;
   localparam logic [31:0] SEC_WR_MASK       = 32'h8000_5FB1;
   localparam logic [31:0] RING_WR_MASK      = 32'h0000_0003;

   // Reset values.
   localparam logic [31:0] VECTOR_RESET      = 32'h0000_0000;
   localparam logic [31:0] TILE_RESET        = 32'h0000_0000;
   localparam logic [31:0] SEC_RESET         = 32'h0000_0000;
   localparam logic [31:0] RING_RESET        = 32'h0000_0000;
   localparam logic [31:0] RAM_SIZE_BYTES    = 32'h0004_0000;

   // Field positions in the tile control register.
   localparam int          TC_DELAY_LSB      = 18;
   localparam int          TC_DELAY_MSB      = 25;
   localparam int          TC_DIV_LSB        = 9;
   localparam int          TC_DIV_MSB        = 17;
   localparam int          TC_RGMII_EN       = 8;
   localparam int          TC_DYN_MODE       = 5;
   localparam int          TC_DIV_EN         = 4;
   localparam int          TC_UTMI_SEL       = 2;
   localparam int          TC_ULPI_EN        = 1;

   // Field positions in the security configuration register.
   localparam int          SC_WRITE_LOCK     = 31;
   localparam int          SC_NO_GLOBAL_DBG  = 14;
   localparam int          SC_OTP_LOCK_ALL   = 12;
   localparam int          SC_SECT_LOCK_LSB  = 8;
   localparam int          SC_SECT_LOCK_MSB  = 11;
   localparam int          SC_OTP_REDUNDANT  = 7;
   localparam int          SC_BOOT_FROM_OTP  = 5;
   localparam int          SC_NO_JTAG_CFG    = 4;
   localparam int          SC_NO_JTAG_TAP    = 0;

   // Ring oscillator control bits.
   localparam int          RC_CORE_EN        = 1;
   localparam int          RC_PERIPH_EN      = 0;

   // Vector address split.
   localparam int          VEC_SPLIT         = 16;

   // Core cycles a stopped oscillator needs before its count is settled.
   localparam int          RING_SETTLE_CYCLES = 10;

endpackage

/* hw/psr_bank.sv */
`timescale 1ns/1ps

module psr_bank (
   input  wire logic        core_clk,
   input  wire logic        resetn,
   input  wire logic        psWrite,
   input  wire logic        psRead,
   input  wire logic [15:0] psResId,
   input  wire logic [31:0] psWrData,
   output logic      [31:0] psRdData,
   output logic             psRdValid,
   input  wire logic        eventTake,
   input  wire logic [15:0] eventVector,
   output logic      [31:0] vectorTarget,
   output logic             rgmiiTxClk,
   output logic             rgmiiTxStrobe,
   output logic             rgmiiPortEn,
   input  wire logic        allThreadsPaused,
   output logic             lowPowerDivide,
   output logic             usbUtmiSelect,
   output logic             ulpiSupportEn,
   input  wire logic [7:0]  bootProcNumber,
   input  wire logic        bootModeOverride,
   input  wire logic        bootCore1Off,
   input  wire logic        bootSkipOtpPoll,
   input  wire logic        bootFromRam,
   input  wire logic        bootFromJtag,
   input  wire logic [1:0]  bootPllMode,
   input  wire logic        otpSecLoad,
   input  wire logic [31:0] otpSecWord,
   output logic             noGlobalDebug,
   output logic             noJtagConfig,
   output logic             noJtagTap,
   output logic             otpLockAll,
   output logic      [3:0]  otpSectorLock,
   output logic             otpRedundancy,
   output logic             bootFromOtp,
   output logic             ringCoreRun,
   output logic             ringPeriphRun,
   input  wire logic        ringCoreCell,
   input  wire logic        ringCoreWire,
   input  wire logic        ringPeriphCell,
   input  wire logic        ringPeriphWire
);

   logic [31:0] vectorBase;
   logic [31:0] tileCtl;
   logic [31:0] secCfg;
   logic [31:0] ringCtl;
   logic [14:0] bootMeta;
   logic [14:0] bootSync;
   logic [31:0] bootStatus;
   logic [8:0]  txCnt;
   logic [7:0]  dlyCnt;
   logic        dlyRun;
   logic [3:0]  ringMeta;
   logic [3:0]  ringSync;
   logic [3:0]  ringLast;
   localparam int RING_COUNT_NUM_W = psr_pkg::RING_COUNT_NUM;

   logic [15:0] ringCount [RING_COUNT_NUM_W];

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);

   // A resource identifier selects a register only when its type byte is a status type.
   function automatic logic psHit(input logic [15:0] resId, input logic [7:0] regNum);
      psHit = (resId[7:0] == psr_pkg::RES_TYPE_STATUS)
              && (resId[15:psr_pkg::RES_REG_SHIFT] == regNum);
   endfunction

   wire         wrVector  = psWrite && psHit(psResId, psr_pkg::REG_VECTOR_BASE);
   wire         wrTile    = psWrite && psHit(psResId, psr_pkg::REG_TILE_CONTROL);
   wire         wrSec     = psWrite && psHit(psResId, psr_pkg::REG_SECURITY_CFG);
   wire         wrRing    = psWrite && psHit(psResId, psr_pkg::REG_RING_CONTROL);
   wire         secLocked = secCfg[psr_pkg::SC_WRITE_LOCK];
   wire         secWrOk   = wrSec && !secLocked;

   wire [8:0]   txDiv     = tileCtl[psr_pkg::TC_DIV_MSB:psr_pkg::TC_DIV_LSB];
   wire [7:0]   txDelay   = tileCtl[psr_pkg::TC_DELAY_MSB:psr_pkg::TC_DELAY_LSB];
   wire         dlyZero   = (txDelay == 8'h00);
   wire         txEn      = tileCtl[psr_pkg::TC_RGMII_EN];
   wire         txAtRise  = txEn && (txCnt == txDiv);
   wire         txAtFall  = txEn && (txCnt == (txDiv >> 1));
   wire [8:0]   txCntNext = txAtRise ? 9'h000 : 9'(txCnt + 9'h001);

   wire         divEn     = tileCtl[psr_pkg::TC_DIV_EN];
   wire         divDyn    = tileCtl[psr_pkg::TC_DYN_MODE];
   wire         next_lowPowerDivide = divEn && (!divDyn || allThreadsPaused);

   // Boot straps in register layout; reserved positions are zero.
   wire [14:0]  bootPins  = {bootProcNumber, bootModeOverride, bootCore1Off, bootSkipOtpPoll,
                             bootFromRam, bootFromJtag, bootPllMode};
   assign bootStatus = {8'h00, bootSync[14:7], 7'h00, bootSync[6], 2'h0,
                        bootSync[5:0]};

   wire [3:0]   ringPins  = {ringPeriphWire, ringPeriphCell, ringCoreWire, ringCoreCell};
   wire [3:0]   ringGate  = {{2{ringCtl[psr_pkg::RC_PERIPH_EN]}},
                             {2{ringCtl[psr_pkg::RC_CORE_EN]}}};
   wire [3:0]   ringEdge  = ringSync & ~ringLast & ringGate;

   wire [7:0]   rdNum     = psResId[15:psr_pkg::RES_REG_SHIFT];
   wire         rdValidId = (psResId[7:0] == psr_pkg::RES_TYPE_STATUS);
   wire [7:0]   rdCntIdx  = 8'(rdNum - psr_pkg::REG_RING_COUNT0);
   wire         rdIsCount = (rdNum >= psr_pkg::REG_RING_COUNT0)
                            && (rdCntIdx < 8'(RING_COUNT_NUM_W));

   // Unmapped numbers, other resource types and reserved bits all read as zero.
   wire [31:0]  rdMux =
      !rdValidId                           ? 32'h0000_0000 :
      (rdNum == psr_pkg::REG_VECTOR_BASE)  ? vectorBase :
      (rdNum == psr_pkg::REG_TILE_CONTROL) ? tileCtl :
      (rdNum == psr_pkg::REG_BOOT_STATUS)  ? bootStatus :
      (rdNum == psr_pkg::REG_SECURITY_CFG) ? secCfg :
      (rdNum == psr_pkg::REG_RING_CONTROL) ? ringCtl :
      rdIsCount                            ? {16'h0000, ringCount[rdCntIdx[1:0]]} :
      (rdNum == psr_pkg::REG_RAM_SIZE)     ? psr_pkg::RAM_SIZE_BYTES :
      32'h0000_0000;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         vectorBase <= psr_pkg::VECTOR_RESET;
         tileCtl    <= psr_pkg::TILE_RESET;
         ringCtl    <= psr_pkg::RING_RESET;
      end else begin
         if (wrVector) begin
            vectorBase <= psWrData & psr_pkg::VECTOR_WR_MASK;
         end
         if (wrTile) begin
            tileCtl <= psWrData & psr_pkg::TILE_WR_MASK;
         end
         if (wrRing) begin
            ringCtl <= psWrData & psr_pkg::RING_WR_MASK;
         end
      end
   end

   // The OTP copy wins over a software write landing in the same cycle.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         secCfg <= psr_pkg::SEC_RESET;
      end else if (otpSecLoad) begin
         secCfg <= otpSecWord & psr_pkg::SEC_WR_MASK;
      end else if (secWrOk) begin
         secCfg <= psWrData & psr_pkg::SEC_WR_MASK;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         psRdData  <= 32'h0000_0000;
         psRdValid <= 1'b0;
      end else begin
         psRdValid <= psRead;
         if (psRead) begin
            psRdData <= rdMux;
         end
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         vectorTarget <= 32'h0000_0000;
      end else if (eventTake) begin
         vectorTarget <= {vectorBase[31:psr_pkg::VEC_SPLIT],
                          eventVector};
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         txCnt      <= 9'h000;
         rgmiiTxClk <= 1'b0;
      end else if (!txEn) begin
         txCnt      <= 9'h000;
         rgmiiTxClk <= 1'b0;
      end else begin
         txCnt <= txCntNext;
         if (txAtRise) begin
            rgmiiTxClk <= 1'b1;
         end else if (txAtFall) begin
            rgmiiTxClk <= 1'b0;
         end
      end
   end

   // A rise that comes before the previous strobe restarts the delay count.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         dlyCnt        <= 8'h00;
         dlyRun        <= 1'b0;
         rgmiiTxStrobe <= 1'b0;
      end else begin
         rgmiiTxStrobe <= 1'b0;
         // At-least ends a count that a smaller delay written mid-run would carry round.
         if (txAtRise) begin
            rgmiiTxStrobe <= dlyZero;
            dlyCnt        <= 8'h01;
            dlyRun        <= !dlyZero;
         end else if (dlyRun) begin
            if (dlyCnt >= txDelay) begin
               rgmiiTxStrobe <= 1'b1;
               dlyRun        <= 1'b0;
            end else begin
               dlyCnt <= 8'(dlyCnt + 8'h01);
            end
         end
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rgmiiPortEn    <= 1'b0;
         lowPowerDivide <= 1'b0;
         usbUtmiSelect  <= 1'b0;
         ulpiSupportEn  <= 1'b0;
         ringCoreRun    <= 1'b0;
         ringPeriphRun  <= 1'b0;
      end else begin
         rgmiiPortEn    <= txEn;
         lowPowerDivide <= next_lowPowerDivide;
         usbUtmiSelect  <= tileCtl[psr_pkg::TC_UTMI_SEL];
         ulpiSupportEn  <= tileCtl[psr_pkg::TC_ULPI_EN];
         ringCoreRun    <= ringCtl[psr_pkg::RC_CORE_EN];
         ringPeriphRun  <= ringCtl[psr_pkg::RC_PERIPH_EN];
      end
   end

   // Security controls come straight from the register flops.
   assign noGlobalDebug = secCfg[psr_pkg::SC_NO_GLOBAL_DBG];
   assign noJtagConfig  = secCfg[psr_pkg::SC_NO_JTAG_CFG];
   assign noJtagTap     = secCfg[psr_pkg::SC_NO_JTAG_TAP];
   assign otpLockAll    = secCfg[psr_pkg::SC_OTP_LOCK_ALL];
   assign otpSectorLock = secCfg[psr_pkg::SC_SECT_LOCK_MSB:psr_pkg::SC_SECT_LOCK_LSB];
   assign otpRedundancy = secCfg[psr_pkg::SC_OTP_REDUNDANT];
   assign bootFromOtp   = secCfg[psr_pkg::SC_BOOT_FROM_OTP];

   // Straps are pins, so they pass two flops before the status register shows them.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         bootMeta <= 15'h0000;
         bootSync <= 15'h0000;
      end else begin
         bootMeta <= bootPins;
         bootSync <= bootMeta;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ringMeta <= 4'h0;
         ringSync <= 4'h0;
         ringLast <= 4'h0;
      end else begin
         ringMeta <= ringPins;
         ringSync <= ringMeta;
         ringLast <= ringSync;
      end
   end

   // The counters have no reset so a system reset leaves the entropy intact.
   // The count is only as fast as the core clock can sample the oscillator.
   always_ff @(posedge core_clk) begin
      for (int i = 0; i < RING_COUNT_NUM_W; i++) begin
         if (ringEdge[i]) begin
            ringCount[i] <= 16'(ringCount[i] + 16'h0001);
         end
      end
   end

   // Helper: cycles since the core oscillators were stopped, saturating.
   logic [3:0] coreStopAge;
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         coreStopAge <= 4'h0;
      end else if (ringCtl[psr_pkg::RC_CORE_EN]) begin
         coreStopAge <= 4'h0;
      end else if (coreStopAge != 4'hF) begin
         coreStopAge <= 4'(coreStopAge + 4'h1);
      end
   end

   localparam int SETTLE = psr_pkg::RING_SETTLE_CYCLES;

   sequence s_rise_seen;
      txAtRise ##1 rgmiiTxClk;
   endsequence

   sequence s_strobe_after_zero;
      txAtRise && (txDelay == 8'h00) ##1 rgmiiTxStrobe;
   endsequence

   a_vector_target_form: assert property (
      eventTake |=> vectorTarget == {$past(vectorBase[31:16]), $past(eventVector)})
      else $error("Vector target not formed from base and event vector.");

   a_vector_reserved_zero: assert property (
      vectorBase[17:0] == 18'h00000)
      else $error("Vector base reserved bits not zero.");

   a_txclk_rise_fall: assert property (
      (txAtRise |-> s_rise_seen) and
      (txAtFall && !txAtRise |=> !rgmiiTxClk))
      else $error("Transmit clock edge not at divider match.");

   a_tx_delay_zero: assert property (
      txAtRise && (txDelay == 8'h00) |-> s_strobe_after_zero)
      else $error("Zero delay strobe missing with the clock rise.");

   a_lowpower_static: assert property (
      divEn && !divDyn ##1 divEn && !divDyn |-> lowPowerDivide)
      else $error("Static divider not applied.");

   a_lowpower_dynamic: assert property (
      divEn && divDyn && !allThreadsPaused |=> !lowPowerDivide)
      else $error("Dynamic divider applied while a thread runs.");

   a_sec_write_lock: assert property (
      secLocked && wrSec && !otpSecLoad |=> $stable(secCfg))
      else $error("Locked security register changed on write.");

   // The counts have no reset and stay unknown even when counting, so the edge pulses stand in for a still count.
   a_ring_stopped_stable: assert property (
      (coreStopAge >= 4'(SETTLE)) |-> !ringCoreRun && !ringEdge[0] && !ringEdge[1])
      else $error("Core oscillator count moved while stopped.");

   a_read_one_cycle: assert property (
      psRead |=> psRdValid ##1 (psRdValid == $past(psRead)))
      else $error("Read answer not one cycle after request.");

   a_ram_size_read: assert property (
      psRead && psHit(psResId, psr_pkg::REG_RAM_SIZE) |=> psRdData == psr_pkg::RAM_SIZE_BYTES)
      else $error("RAM size read wrong.");

   a_reserved_read_zero: assert property (
      psRead && psHit(psResId, psr_pkg::REG_TILE_CONTROL) |=> psRdData[31:26] == 6'h00)
      else $error("Tile control reserved bits read nonzero.");

   a_port_enable_copy: assert property (
      rgmiiPortEn == $past(txEn))
      else $error("Port enable does not follow tile control bit.");

   a_ring_run_copy: assert property (
      {ringCoreRun, ringPeriphRun} == $past(ringCtl[1:0]))
      else $error("Oscillator run outputs do not follow control bits.");

   a_sec_otp_load: assert property (
      otpSecLoad |=> secCfg == ($past(otpSecWord) & psr_pkg::SEC_WR_MASK))
      else $error("Security word not loaded from OTP copy.");

endmodule

/* testbench/psr_bank_bench.sv */
`timescale 1ns/1ps

module psr_bank_bench;
   logic        core_clk, resetn, psWrite, psRead, psRdValid, eventTake;
   logic [15:0] psResId, eventVector;
   logic [31:0] psWrData, psRdData, vectorTarget, otpSecWord, sr;
   logic        rgmiiTxClk, rgmiiTxStrobe, rgmiiPortEn, allThreadsPaused, lowPowerDivide;
   logic        usbUtmiSelect, ulpiSupportEn, bootModeOverride, bootCore1Off, bootSkipOtpPoll;
   logic        bootFromRam, bootFromJtag, otpSecLoad, noGlobalDebug, noJtagConfig, noJtagTap;
   logic        otpLockAll, otpRedundancy, bootFromOtp, ringCoreRun, ringPeriphRun;
   logic        ringCoreCell, ringCoreWire, ringPeriphCell, ringPeriphWire;
   logic [7:0]  bootProcNumber;
   logic [1:0]  bootPllMode;
   logic [3:0]  otpSectorLock;
   logic [31:0] expQ[$];
   logic [31:0] maskQ[$];
   logic [31:0] secIn[5];
   logic [31:0] d;
   integer      seed;
   int          n_mismatch;
   int          tests_run;

   psr_bank psr_bank_i (
      .core_clk(core_clk), .resetn(resetn), .psWrite(psWrite), .psRead(psRead),
      .psResId(psResId), .psWrData(psWrData), .psRdData(psRdData), .psRdValid(psRdValid),
      .eventTake(eventTake), .eventVector(eventVector), .vectorTarget(vectorTarget),
      .rgmiiTxClk(rgmiiTxClk), .rgmiiTxStrobe(rgmiiTxStrobe), .rgmiiPortEn(rgmiiPortEn),
      .allThreadsPaused(allThreadsPaused), .lowPowerDivide(lowPowerDivide),
      .usbUtmiSelect(usbUtmiSelect), .ulpiSupportEn(ulpiSupportEn),
      .bootProcNumber(bootProcNumber), .bootModeOverride(bootModeOverride),
      .bootCore1Off(bootCore1Off), .bootSkipOtpPoll(bootSkipOtpPoll),
      .bootFromRam(bootFromRam), .bootFromJtag(bootFromJtag), .bootPllMode(bootPllMode),
      .otpSecLoad(otpSecLoad), .otpSecWord(otpSecWord), .noGlobalDebug(noGlobalDebug),
      .noJtagConfig(noJtagConfig), .noJtagTap(noJtagTap), .otpLockAll(otpLockAll),
      .otpSectorLock(otpSectorLock), .otpRedundancy(otpRedundancy),
      .bootFromOtp(bootFromOtp), .ringCoreRun(ringCoreRun), .ringPeriphRun(ringPeriphRun),
      .ringCoreCell(ringCoreCell), .ringCoreWire(ringCoreWire),
      .ringPeriphCell(ringPeriphCell), .ringPeriphWire(ringPeriphWire)
   );

   initial begin
      core_clk = 1'h0;
      forever #2.5 core_clk = ~core_clk;
   end

   function automatic logic [15:0] rid(input logic [7:0] r);
      return {r, 8'h0B};
   endfunction

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Reads are answered a cycle late, so expectations wait here in issue order.
   always @(negedge core_clk) begin
      if (psRdValid === 1'h1) begin
         chk("read data", expQ.pop_front(), psRdData & maskQ.pop_front());
      end
   end

   task automatic settle(input int n);
      repeat (n) @(posedge core_clk);
      @(negedge core_clk);
   endtask

   task automatic wr(input logic [15:0] id, input logic [31:0] data);
      @(posedge core_clk);
      psWrite <= 1'h1;
      psResId <= id;
      psWrData <= data;
      @(posedge core_clk);
      psWrite <= 1'h0;
   endtask

   task automatic rd(input logic [15:0] id, input logic [31:0] exp,
                     input logic [31:0] mask = 32'hFFFF_FFFF);
      @(posedge core_clk);
      psRead <= 1'h1;
      psResId <= id;
      expQ.push_back(exp & mask);
      maskQ.push_back(mask);
      @(posedge core_clk);
      psRead <= 1'h0;
   endtask

   task automatic do_reset();
      resetn <= 1'h0;
      repeat (6) @(posedge core_clk);
      resetn <= 1'h1;
   endtask

   // The divider may be mid-period after a write, so the first rise is skipped to.
   task automatic meas(input int div, input int dly);
      logic prev;
      int   t;
      int   hi;
      int   st;
      prev = 1'h1;
      t = 0;
      while (!(prev === 1'h0 && rgmiiTxClk === 1'h1) && t < 600) begin
         prev = rgmiiTxClk;
         @(negedge core_clk);
         t++;
      end
      hi = 0;
      st = -1;
      t = 0;
      do begin
         if (rgmiiTxClk === 1'h1) hi++;
         if (rgmiiTxStrobe === 1'h1 && st < 0) st = t;
         prev = rgmiiTxClk;
         @(negedge core_clk);
         t++;
      end while (!(prev === 1'h0 && rgmiiTxClk === 1'h1) && t < 40);
      chk("tx period", div + 1, t);
      chk("tx high", (div >> 1) + 1, hi);
      chk("tx strobe", dly, st);
   endtask

   task automatic end_sim();
      if (expQ.size() != 0) begin
         n_mismatch++;
         $display("mismatch pending reads expected 0 seen %0d", expQ.size());
      end
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      #(5 * 20000);
      n_mismatch++;
      $display("mismatch watchdog expected done seen timeout");
      end_sim();
   end

   initial begin
      seed = 32'h45BC;
      n_mismatch = 0;
      tests_run = 0;
      {resetn, psWrite, psRead, eventTake, otpSecLoad, allThreadsPaused} = 6'h0;
      {ringCoreCell, ringCoreWire, ringPeriphCell, ringPeriphWire} = 4'h0;
      psResId = 16'h0;
      psWrData = 32'h0;
      eventVector = 16'h0;
      otpSecWord = 32'h0;
      {bootProcNumber, bootModeOverride, bootCore1Off, bootSkipOtpPoll} = $random(seed);
      {bootFromRam, bootFromJtag, bootPllMode} = $random(seed);
      secIn = '{32'h7FFF_FFFF, 32'h8000_0001, 32'h0000_0000, 32'h0000_1234, 32'hFFFF_FFFF};
      do_reset();
      settle(3);
      d = {8'h00, bootProcNumber, 7'h00, bootModeOverride, 2'h0, bootCore1Off,
           bootSkipOtpPoll, bootFromRam, bootFromJtag, bootPllMode};
      rd(rid(8'h01), 32'h0);
      rd(rid(8'h02), 32'h0);
      rd(rid(8'h06), 32'h0);
      rd(rid(8'h0C), psr_pkg::RAM_SIZE_BYTES, 32'hFFFF_FFFC);
      rd(rid(8'h0C), 32'h0, 32'h0000_0003);
      wr(rid(8'h03), 32'hFFFF_FFFF);
      rd(rid(8'h03), d);
      wr(rid(8'h04), 32'hFFFF_FFFF);
      rd(rid(8'h04), 32'h0);
      for (int i = 0; i < 4; i++) begin
         d = (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h0 : $random(seed);
         wr(rid(8'h02), d);
         wr({8'h02, 8'h0A}, ~d);
         rd(rid(8'h02), d & 32'h03FF_FF36);
         rd({8'h02, 8'h0A}, 32'h0);
         settle(2);
         chk("tile pins", {d[8], d[2], d[1]}, {rgmiiPortEn, usbUtmiSelect, ulpiSupportEn});
      end
      for (int i = 0; i < 2; i++) begin
         d = $random(seed);
         wr(rid(8'h01), d);
         rd(rid(8'h01), d & 32'hFFFC_0000);
         @(posedge core_clk);
         eventTake <= 1'h1;
         eventVector <= $random(seed);
         @(posedge core_clk);
         eventTake <= 1'h0;
         @(negedge core_clk);
         chk("vector target", {d[31:18], 2'h0, eventVector}, vectorTarget);
      end
      wr(rid(8'h02), {6'h0, 8'h02, 9'h005, 9'h100});
      meas(5, 2);
      wr(rid(8'h02), {6'h0, 8'h00, 9'h003, 9'h100});
      meas(3, 0);
      wr(rid(8'h02), 32'h0000_0010);
      settle(2);
      chk("low power", 32'h1, lowPowerDivide);
      wr(rid(8'h02), 32'h0000_0030);
      for (int i = 0; i < 4; i++) begin
         @(posedge core_clk);
         allThreadsPaused <= i[0];
         settle(2);
         chk("low power", i[0], lowPowerDivide);
      end
      wr(rid(8'h02), 32'h0000_0020);
      settle(2);
      chk("low power", 32'h0, lowPowerDivide);
      // A shadow copy tracks the lock: the OTP load always wins, writes only while unlocked.
      sr = 32'h0;
      for (int i = 0; i < 5; i++) begin
         if (i == 3) begin
            @(posedge core_clk);
            otpSecLoad <= 1'h1;
            otpSecWord <= secIn[i];
            @(posedge core_clk);
            otpSecLoad <= 1'h0;
         end else begin
            wr(rid(8'h05), secIn[i]);
         end
         if (i == 3 || !sr[31]) sr = secIn[i] & 32'h8000_5FB1;
         rd(rid(8'h05), sr);
         settle(1);
         chk("security pins", {sr[14], sr[12], sr[11:8], sr[7], sr[5], sr[4], sr[0]},
             {noGlobalDebug, otpLockAll, otpSectorLock, otpRedundancy, bootFromOtp,
              noJtagConfig, noJtagTap});
      end
      wr(rid(8'h06), 32'hFFFF_FFFF);
      rd(rid(8'h06), 32'h0000_0003);
      settle(2);
      chk("ring run", 32'h3, {ringCoreRun, ringPeriphRun});
      repeat (12) begin
         @(posedge core_clk);
         {ringCoreCell, ringCoreWire, ringPeriphCell, ringPeriphWire} <= $random(seed);
      end
      wr(rid(8'h06), 32'h0000_0001);
      settle(2);
      chk("ring run", 32'h1, {ringCoreRun, ringPeriphRun});
      wr(rid(8'h06), 32'h0);
      settle(10);
      for (int k = 0; k < 4; k++) rd(rid(8'h07 + k[7:0]), 32'h0, 32'hFFFF_0000);
      wr(rid(8'h02), 32'h0000_0106);
      do_reset();
      @(negedge core_clk);
      chk("reset pins", 32'h0, {rgmiiPortEn, usbUtmiSelect, ulpiSupportEn, noJtagTap});
      settle(2);
      rd(rid(8'h02), 32'h0);
      rd(rid(8'h05), 32'h0);
      for (int k = 0; k < 4; k++) rd(rid(8'h07 + k[7:0]), 32'h0, 32'hFFFF_0000);
      settle(3);
      end_sim();
   end
endmodule
